// *** hdl/bwp_pkg.sv ***
// types shared by the period tracker and its write-retire policy
`include "bwp_regs.svh"

package bwp_pkg;

    // one observed cycle on the cpu bus, same clock as the tracker
    typedef struct packed {
        logic valid;
        logic to_dram;
        logic from_cpu;
    } bwp_cycle_type;

    // state of the write queue and read traffic, from the dram side logic
    typedef struct packed {
        logic                     bus_idle;
        logic [`BWP_QUEUE_W-1:0]  queued;
        logic                     queue_full;
        logic                     above_threshold;
        logic                     read_pending;
        logic                     read_arrive;
        logic                     base_flush;
    } bwp_queue_type;

    typedef enum logic [1:0] {
        BWP_PERIOD_NONE,
        BWP_PERIOD_HOST,
        BWP_PERIOD_MEM,
        BWP_PERIOD_BOTH
    } bwp_period_type;

    typedef struct packed {
        logic [`BWP_WAIT_W-1:0] wait_cnt;
        logic                   flush;
    } bwp_retire_state_type;

    typedef struct packed {
        logic [`BWP_DATA_W-1:0]  timers;
        logic                    host_en;
        logic                    mem_en;
        logic [`BWP_CNT_W-1:0]   host_cnt;
        logic [`BWP_CNT_W-1:0]   mem_cnt;
        logic                    host_period;
        logic                    mem_period;
        logic [`BWP_ENTRY_W-1:0] host_entries;
        logic [`BWP_ENTRY_W-1:0] mem_entries;
        logic [`BWP_DATA_W-1:0]  rdata;
    } bwp_state_type;

endpackage

// *** hdl/bwp_regs.svh ***
// register map, field positions, reset values and timing counts of the period tracker
`ifndef BWP_REGS_SVH
`define BWP_REGS_SVH

`define BWP_ADDR_W              8
`define BWP_DATA_W              8
`define BWP_TIMERS_ADDR         8'h5e
`define BWP_CTRL_ADDR           8'h5f
`define BWP_STATUS_ADDR         8'h60
`define BWP_COUNTS_ADDR         8'h61
`define BWP_HOST_ENTRIES_ADDR   8'h62
`define BWP_MEM_ENTRIES_ADDR    8'h63
`define BWP_TIMERS_RESET        8'h00
`define BWP_HOST_PRESET_MSB     7
`define BWP_HOST_PRESET_LSB     4
`define BWP_MEM_PRESET_MSB      3
`define BWP_MEM_PRESET_LSB      0
`define BWP_CTRL_FIXED_BIT      7
`define BWP_HOST_EN_BIT         2
`define BWP_MEM_EN_BIT          1
`define BWP_STATUS_HOST_BIT     0
`define BWP_STATUS_MEM_BIT      1
`define BWP_CNT_W               4
`define BWP_ENTRY_W             8
`define BWP_HOST_WAIT_CYCLES    8
`define BWP_WAIT_W              4
`define BWP_BOTH_MIN_QUEUE      4'h2
`define BWP_QUEUE_W             4

`endif

// *** hdl/bwp_tracker.sv ***
// bandwidth period tracker: host and memory streak periods steering write retire
//
// Notes on behaviour
// - host preset sits in timers [7:4]; loaded at reset and memory-period entry.
// - each non-dram cycle issued by the cpu lowers the host counter.
// - a dram cycle before the host counter hits zero reloads it.
// - host period only exists while its enable bit is one.
// - host counter at zero enters host period, adjusting write retire.
// - host preset zero means always in period; n needs n cycles.
// - memory preset sits in timers [3:0]; loaded at reset and host-period entry.
// - each dram cycle from cpu or upstream master lowers memory counter.
// - a non-dram cycle before memory counter hits zero reloads it.
// - memory period only exists while its enable bit is one.
// - memory counter at zero enters memory period, adjusting write retire.
// - memory preset zero means always in period; fifteen needs fifteen cycles.
// - host period, idle bus: wait eight cycles, abandon on any read.
// - memory period, idle bus: flush once no read is pending.
// - busy bus, either period: reads defer writes unless queue full.
// - outside both periods the base write-retire policy applies.
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/10ps
`include "bwp_regs.svh"

module bwp_tracker #(
    parameter int CNT_W       = `BWP_CNT_W,
    parameter int WAIT_CYCLES = `BWP_HOST_WAIT_CYCLES
) (
    input  wire logic                    core_clk,
    input  wire logic                    rst,
    input  wire logic [`BWP_ADDR_W-1:0]  reg_addr,
    input  wire logic [`BWP_DATA_W-1:0]  reg_wdata,
    input  wire logic                    reg_write,
    input  wire logic                    reg_read,
    output logic      [`BWP_DATA_W-1:0]  reg_rdata,
    input  wire bwp_pkg::bwp_cycle_type  cpu_cycle,
    input  wire bwp_pkg::bwp_queue_type  queue,
    output logic                         host_favoured_period,
    output logic                         memory_streak_period,
    output logic                         write_flush
);

    bwp_pkg::bwp_state_type  state;
    bwp_pkg::bwp_state_type  next_state;
    bwp_pkg::bwp_period_type period;

    logic [CNT_W-1:0] host_period_preset;
    logic [CNT_W-1:0] memory_period_preset;
    logic             host_period_enable;
    logic             memory_period_enable;
    logic             cyc_dram;
    logic             cyc_other;
    logic             cyc_cpu_other;
    logic             host_entering;
    logic             mem_entering;
    logic             host_rise;
    logic             host_en_next;
    logic             mem_en_next;
    logic [CNT_W-1:0] host_base;
    logic [CNT_W-1:0] mem_base;
    logic [CNT_W-1:0] host_next;
    logic [CNT_W-1:0] mem_next;
    logic             wr_timers;
    logic             wr_ctrl;
    logic             wr_host_entries;
    logic             wr_mem_entries;
    logic [`BWP_DATA_W-1:0] ctrl_view;
    logic [`BWP_DATA_W-1:0] status_view;
    logic [`BWP_DATA_W-1:0] read_value;

    // field views of the stored registers
    always_comb begin
        host_period_preset   = CNT_W'(state.timers[`BWP_HOST_PRESET_MSB:`BWP_HOST_PRESET_LSB]);
        memory_period_preset = CNT_W'(state.timers[`BWP_MEM_PRESET_MSB:`BWP_MEM_PRESET_LSB]);
        host_period_enable   = state.host_en;
        memory_period_enable = state.mem_en;
    end

    // cycle classification; inputs share core_clk so need no synchroniser
    always_comb begin
        cyc_dram      = cpu_cycle.valid && cpu_cycle.to_dram;
        cyc_other     = cpu_cycle.valid && !cpu_cycle.to_dram;
        // non-dram cycles from upstream masters do not lower the host counter
        cyc_cpu_other = cyc_other && cpu_cycle.from_cpu;
    end

    // host entry is settled first, so the two cross reloads cannot loop
    always_comb begin
        host_en_next = wr_ctrl ? reg_wdata[`BWP_HOST_EN_BIT] : host_period_enable;
        mem_en_next  = wr_ctrl ? reg_wdata[`BWP_MEM_EN_BIT] : memory_period_enable;
        if (cyc_dram) begin
            host_base = host_period_preset;
        end else if (cyc_cpu_other && state.host_cnt != '0) begin
            host_base = state.host_cnt - CNT_W'(1);
        end else begin
            host_base = state.host_cnt;
        end
        if (cyc_other) begin
            mem_base = memory_period_preset;
        end else if (cyc_dram && state.mem_cnt != '0) begin
            mem_base = state.mem_cnt - CNT_W'(1);
        end else begin
            mem_base = state.mem_cnt;
        end
        host_entering = host_en_next && !state.host_period && (host_base == '0);
        mem_next      = host_entering ? memory_period_preset : mem_base;
        mem_entering  = mem_en_next && !state.mem_period && (mem_next == '0);
        host_next     = mem_entering ? host_period_preset : host_base;
        // entry that survives the memory reload
        host_rise     = host_entering && (host_next == '0);
    end

    // register write decode
    always_comb begin
        wr_timers       = reg_write && (reg_addr == `BWP_TIMERS_ADDR);
        wr_ctrl         = reg_write && (reg_addr == `BWP_CTRL_ADDR);
        wr_host_entries = reg_write && (reg_addr == `BWP_HOST_ENTRIES_ADDR);
        wr_mem_entries  = reg_write && (reg_addr == `BWP_MEM_ENTRIES_ADDR);
    end

    // register read views
    always_comb begin
        ctrl_view = '0;
        // top bit is a fixed one, as the reserved field reads
        ctrl_view[`BWP_CTRL_FIXED_BIT] = 1'b1;
        ctrl_view[`BWP_HOST_EN_BIT]    = state.host_en;
        ctrl_view[`BWP_MEM_EN_BIT]     = state.mem_en;
        status_view = '0;
        status_view[`BWP_STATUS_HOST_BIT] = state.host_period;
        status_view[`BWP_STATUS_MEM_BIT]  = state.mem_period;
        case (reg_addr)
            `BWP_TIMERS_ADDR: begin
                read_value = state.timers;
            end
            `BWP_CTRL_ADDR: begin
                read_value = ctrl_view;
            end
            `BWP_STATUS_ADDR: begin
                read_value = status_view;
            end
            `BWP_COUNTS_ADDR: begin
                read_value = `BWP_DATA_W'({state.host_cnt, state.mem_cnt});
            end
            `BWP_HOST_ENTRIES_ADDR: begin
                read_value = state.host_entries;
            end
            `BWP_MEM_ENTRIES_ADDR: begin
                read_value = state.mem_entries;
            end
            default: begin
                // unmapped addresses answer zero
                read_value = '0;
            end
        endcase
    end

    always_comb begin
        next_state = state;

        // register file; presets take effect at the next reload, not at once
        if (wr_timers) begin
            next_state.timers = reg_wdata;
        end
        if (wr_ctrl) begin
            next_state.host_en = reg_wdata[`BWP_HOST_EN_BIT];
            next_state.mem_en  = reg_wdata[`BWP_MEM_EN_BIT];
        end

        // read data stand only in the cycle after the strobe
        next_state.rdata = reg_read ? read_value : '0;

        // counters after own and cross reloads
        next_state.host_cnt = host_next;
        next_state.mem_cnt  = mem_next;

        next_state.host_period = next_state.host_en && (next_state.host_cnt == '0);
        next_state.mem_period  = next_state.mem_en && (next_state.mem_cnt == '0);

        // entry counters saturate; an entry in the clearing cycle still counts
        if (wr_host_entries) begin
            next_state.host_entries = host_rise ? `BWP_ENTRY_W'(1) : '0;
        end else if (host_rise && state.host_entries != '1) begin
            next_state.host_entries = state.host_entries + `BWP_ENTRY_W'(1);
        end
        if (wr_mem_entries) begin
            next_state.mem_entries = mem_entering ? `BWP_ENTRY_W'(1) : '0;
        end else if (mem_entering && state.mem_entries != '1) begin
            next_state.mem_entries = state.mem_entries + `BWP_ENTRY_W'(1);
        end
    end

    // reset value of the timers register is zero, so counters start at the preset
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state        <= '0;
            state.timers <= `BWP_TIMERS_RESET;
        end else begin
            state <= next_state;
        end
    end

    // period seen by the retire policy
    always_comb begin
        case ({state.mem_period, state.host_period})
            2'h1: begin
                period = bwp_pkg::BWP_PERIOD_HOST;
            end
            2'h2: begin
                period = bwp_pkg::BWP_PERIOD_MEM;
            end
            2'h3: begin
                period = bwp_pkg::BWP_PERIOD_BOTH;
            end
            default: begin
                period = bwp_pkg::BWP_PERIOD_NONE;
            end
        endcase
    end

    bwp_write_retire #(
        .WAIT_CYCLES (WAIT_CYCLES)
    ) u_retire (
        .core_clk    (core_clk),
        .rst         (rst),
        .period      (period),
        .queue       (queue),
        .write_flush (write_flush)
    );

    assign reg_rdata            = state.rdata;
    assign host_favoured_period = state.host_period;
    assign memory_streak_period = state.mem_period;

endmodule

// *** hdl/bwp_write_retire.sv ***
// write-retire decision for queued dram writes, steered by the current period
`timescale 1ns/10ps
`include "bwp_regs.svh"

module bwp_write_retire #(
    parameter int WAIT_CYCLES = `BWP_HOST_WAIT_CYCLES
) (
    input  wire logic                   core_clk,
    input  wire logic                   rst,
    input  wire bwp_pkg::bwp_period_type period,
    input  wire bwp_pkg::bwp_queue_type  queue,
    output logic                        write_flush
);

    localparam logic [`BWP_WAIT_W-1:0] WAIT_LAST = WAIT_CYCLES[`BWP_WAIT_W-1:0];

    bwp_pkg::bwp_retire_state_type state;
    bwp_pkg::bwp_retire_state_type next_state;
    logic                          queued_any;
    logic                          busy_flush;

    always_comb begin
        next_state = state;
        queued_any = queue.queued != '0;
        // busy bus in either period: reads win until the queue is full
        busy_flush = queue.above_threshold && (queue.queue_full || !queue.read_arrive);
        case (period)
            bwp_pkg::BWP_PERIOD_HOST: begin
                if (queue.bus_idle) begin
                    if (!queued_any || queue.read_arrive) begin
                        next_state.wait_cnt = '0;
                    end else if (state.wait_cnt != WAIT_LAST) begin
                        next_state.wait_cnt = state.wait_cnt + 1'b1;
                    end
                    next_state.flush = queued_any && !queue.read_arrive
                                       && (state.wait_cnt == WAIT_LAST);
                end else begin
                    next_state.wait_cnt = '0;
                    next_state.flush = busy_flush;
                end
            end
            bwp_pkg::BWP_PERIOD_MEM: begin
                next_state.wait_cnt = '0;
                if (queue.bus_idle) begin
                    next_state.flush = queued_any && !queue.read_pending;
                end else begin
                    next_state.flush = busy_flush;
                end
            end
            bwp_pkg::BWP_PERIOD_BOTH: begin
                next_state.wait_cnt = '0;
                // odd setting: threshold, or two queued with no reads about
                next_state.flush = queue.above_threshold
                                   || (!queue.read_pending
                                       && queue.queued >= `BWP_BOTH_MIN_QUEUE);
            end
            default: begin
                next_state.wait_cnt = '0;
                next_state.flush = queue.base_flush;
            end
        endcase
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign write_flush = state.flush;

endmodule

// *** verification/bwp_far_model.sv ***
// far side model: cpu bus masters and the dram side queue levels
`timescale 1ns/10ps
module bwp_far_model (
    input  wire logic                   core_clk,
    input  wire logic                   rst,
    input  wire bwp_pkg::bwp_cycle_type req,
    input  wire bwp_pkg::bwp_queue_type req_queue,
    output bwp_pkg::bwp_cycle_type      cpu_cycle,
    output bwp_pkg::bwp_queue_type      queue
);
    logic alt;
    // idle lines wander so a stale cycle type is never trusted
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst)
            alt <= 1'b0;
        else
            alt <= ~alt;
    end
    always_comb begin
        cpu_cycle = req;
        if (!req.valid)
            cpu_cycle = {1'b0, alt, ~alt};
    end
    assign queue = req_queue;
endmodule

// *** verification/bwp_tracker_monitor.sv ***
// assertions on the period tracker ports
`timescale 1ns/10ps
`include "bwp_regs.svh"
module bwp_tracker_monitor (
    input wire logic                   core_clk,
    input wire logic                   rst,
    input wire logic [7:0]             reg_addr,
    input wire logic [7:0]             reg_wdata,
    input wire logic                   reg_write,
    input wire bwp_pkg::bwp_cycle_type cpu_cycle,
    input wire bwp_pkg::bwp_queue_type queue,
    input wire logic                   host_favoured_period,
    input wire logic                   memory_streak_period,
    input wire logic                   write_flush
);
    logic [7:0] tm;
    logic       hen;
    logic       men;
    logic [3:0] qcnt;
    logic       hst;
    logic       one;
    logic       none;
    logic       nd;
    logic       dr;
    logic       qual;
    logic       h1;
    logic       m1;
    assign hst  = host_favoured_period && !memory_streak_period;
    assign one  = host_favoured_period ^ memory_streak_period;
    assign none = !host_favoured_period && !memory_streak_period;
    assign nd   = cpu_cycle.valid && !cpu_cycle.to_dram;
    assign dr   = cpu_cycle.valid && cpu_cycle.to_dram;
    assign qual = hst && queue.bus_idle && queue.queued != 4'h0 && !queue.read_arrive;
    assign h1   = hen && tm[7:4] == 4'h1;
    assign m1   = men && tm[3:0] == 4'h1;
    // shadow of presets and enables; qcnt counts qualifying idle cycles
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            tm   <= 8'h00;
            hen  <= 1'b0;
            men  <= 1'b0;
            qcnt <= 4'h0;
        end else begin
            if (reg_write && reg_addr == `BWP_TIMERS_ADDR)
                tm <= reg_wdata;
            if (reg_write && reg_addr == `BWP_CTRL_ADDR)
                {hen, men} <= reg_wdata[2:1];
            qcnt <= qual ? qcnt + {3'h0, qcnt != 4'hf} : 4'h0;
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    a_host_gate: assert property (!hen && $past(!hen) |-> !host_favoured_period)
        else $error("host period while disabled");
    a_mem_gate: assert property (!men && $past(!men) |-> !memory_streak_period)
        else $error("memory period while disabled");
    a_host_reload: assert property (dr && tm[7:4] != 4'h0 |=> !host_favoured_period)
        else $error("host counter not reloaded");
    a_mem_reload: assert property (nd && tm[3:0] != 4'h0 |=> !memory_streak_period)
        else $error("memory counter not reloaded");
    a_host_entry: assert property ((dr && h1) ##1 (nd && cpu_cycle.from_cpu && h1)
        |=> host_favoured_period) else $error("host period not entered");
    a_mem_entry: assert property ((nd && m1) ##1 (dr && !cpu_cycle.from_cpu && m1)
        |=> memory_streak_period) else $error("memory period not entered");
    a_base_policy: assert property (none [*3] |-> write_flush == $past(queue.base_flush))
        else $error("base policy not followed");
    a_mem_idle_flush: assert property ((memory_streak_period && !host_favoured_period
        && queue.bus_idle) [*3] |-> write_flush == $past(queue.queued != 4'h0
        && !queue.read_pending)) else $error("memory period idle flush wrong");
    a_busy_defer: assert property ((one && !queue.bus_idle) [*3] |-> write_flush ==
        $past(queue.above_threshold && (queue.queue_full || !queue.read_arrive)))
        else $error("busy bus flush wrong");
    a_host_wait: assert property (qual && $past(qual) && qcnt < 4'h9 |-> !write_flush)
        else $error("host flush too early");
    a_host_flush: assert property (qcnt >= 4'h9 |-> write_flush)
        else $error("host flush missing");
    c_host_to_mem: cover property (host_favoured_period ##1 memory_streak_period);
    c_host_wait: cover property (qcnt == 4'hc);
    c_mem_flush: cover property (memory_streak_period && write_flush);
endmodule
bind bwp_tracker bwp_tracker_monitor u_bwp_tracker_monitor (.core_clk, .rst, .reg_addr,
    .reg_wdata, .reg_write, .cpu_cycle, .queue, .host_favoured_period, .memory_streak_period,
    .write_flush);

// *** verification/tb.sv ***
// self-checking bench for the bandwidth period tracker
`timescale 1ns/10ps
module tb;
    logic                   core_clk;
    logic                   rst;
    logic [7:0]             reg_addr;
    logic [7:0]             reg_wdata;
    logic                   reg_write;
    logic                   reg_read;
    logic [7:0]             reg_rdata;
    bwp_pkg::bwp_cycle_type req;
    bwp_pkg::bwp_queue_type req_queue;
    bwp_pkg::bwp_cycle_type cpu_cycle;
    bwp_pkg::bwp_queue_type queue;
    logic                   host_favoured_period;
    logic                   memory_streak_period;
    logic                   write_flush;
    logic [31:0]            seed;
    logic [31:0]            r;
    logic [7:0]             m_tm;
    logic [3:0]             m_hc;
    logic [3:0]             m_mc;
    logic                   m_he;
    logic                   m_me;
    logic                   m_hp;
    logic                   m_mp;
    int                     err_total;
    int                     compares;
    bwp_far_model u_bwp_far_model (.core_clk, .rst, .req, .req_queue, .cpu_cycle, .queue);
    bwp_tracker #(.WAIT_CYCLES(8)) u_bwp_tracker (.core_clk, .rst, .reg_addr, .reg_wdata,
        .reg_write, .reg_read, .reg_rdata, .cpu_cycle, .queue, .host_favoured_period,
        .memory_streak_period, .write_flush);
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    function automatic logic [31:0] nxt();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic cmp8(input string what, input logic [7:0] e, input logic [7:0] g);
        compares++;
        if (g !== e) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic cmp1(input string what, input logic e, input logic g);
        compares++;
        if (g !== e) begin
            err_total++;
            $display("ERROR %s expected %b seen %b", what, e, g);
        end
    endtask
    task automatic final_report();
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // reference counters; entering one period reloads the other counter
    task automatic step(input bwp_pkg::bwp_cycle_type c);
        logic nh;
        logic nm;
        if (c.valid && c.to_dram) begin
            m_hc = m_tm[7:4];
            m_mc = (m_mc == 4'h0) ? 4'h0 : m_mc - 4'h1;
        end else if (c.valid) begin
            m_mc = m_tm[3:0];
            if (c.from_cpu)
                m_hc = (m_hc == 4'h0) ? 4'h0 : m_hc - 4'h1;
        end
        nh = m_he && m_hc == 4'h0;
        if (nh && !m_hp)
            m_mc = m_tm[3:0];
        nm = m_me && m_mc == 4'h0;
        if (nm && !m_mp) begin
            m_hc = m_tm[7:4];
            nh = m_he && m_hc == 4'h0;
        end
        m_hp = nh;
        m_mp = nm;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        req       <= 3'h0;
        reg_write <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_write <= 1'b0;
        if (a == 8'h5e)
            m_tm = d;
        if (a == 8'h5f)
            {m_he, m_me} = d[2:1];
        step(3'h0);
    endtask
    task automatic rdc(input string what, input logic [7:0] a, input logic [7:0] e);
        @(posedge core_clk);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_read <= 1'b0;
        #1 cmp8(what, e, reg_rdata);
    endtask
    task automatic cyc(input bwp_pkg::bwp_cycle_type c);
        r = nxt();
        @(posedge core_clk);
        req       <= c;
        req_queue <= r[9:0];
        step(c);
    endtask
    task automatic chk();
        @(posedge core_clk);
        req <= 3'h0;
        repeat (2) @(posedge core_clk);
        #1 cmp1("host period", m_hp, host_favoured_period);
        cmp1("memory period", m_mp, memory_streak_period);
        rdc("status", 8'h60, {6'h00, m_mp, m_hp});
        rdc("counts", 8'h61, {m_hc, m_mc});
    endtask
    task automatic chkf(input bwp_pkg::bwp_queue_type q, input int n, input logic e);
        @(posedge core_clk);
        req_queue <= q;
        repeat (n) @(posedge core_clk);
        #1 cmp1("write flush", e, write_flush);
    endtask
    initial begin
        #2000000;
        err_total++;
        final_report();
    end
    initial begin
        seed = 32'h53c9beaa;
        rst = 1'b1;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_write = 1'b0;
        reg_read = 1'b0;
        req = 3'h0;
        req_queue = 10'h000;
        {m_tm, m_hc, m_mc, m_he, m_me, m_hp, m_mp} = 20'h00000;
        err_total = 0;
        compares = 0;
        repeat (12) @(posedge core_clk);
        rst <= 1'b0;
        rdc("timers", 8'h5e, 8'h00);
        rdc("control", 8'h5f, 8'h80);
        rdc("unmapped", 8'h70, 8'h00);
        wr(8'h60, 8'hff);
        r = nxt();
        wr(8'h5e, r[7:0]);
        rdc("timers", 8'h5e, r[7:0]);
        wr(8'h5e, 8'h2f);
        cyc(3'h4);
        cyc(3'h7);
        cyc(3'h4);
        wr(8'h5f, 8'h06);
        rdc("control", 8'h5f, 8'h86);
        repeat (14) cyc({2'h3, r[0]});
        chk();
        cyc(3'h6);
        chk();
        cyc(3'h5);
        cyc(3'h5);
        cyc(3'h4);
        chk();
        rdc("host entries", 8'h62, 8'h01);
        rdc("memory entries", 8'h63, 8'h01);
        wr(8'h5e, 8'h30);
        wr(8'h5f, 8'h02);
        cyc(3'h5);
        chk();
        repeat (40) begin
            r = nxt();
            wr(8'h5e, {{1'b0, r[2:0]} + 4'h1, {1'b0, r[6:4]} + 4'h1});
            cyc(3'h7);
            wr(8'h5f, {5'h00, r[9:8], 1'b0});
            repeat (r[13:10] + 5'h01) cyc({r[3] | r[4], r[0], r[1] | r[2]});
            chk();
        end
        wr(8'h5f, 8'h00);
        chkf(10'h001, 3, 1'b1);
        chkf(10'h3fe, 3, 1'b0);
        wr(8'h5e, 8'h30);
        wr(8'h5f, 8'h02);
        cyc(3'h5);
        chk();
        chkf(10'h260, 3, 1'b1);
        chkf(10'h264, 3, 1'b0);
        chkf(10'h00a, 3, 1'b0);
        chkf(10'h01a, 3, 1'b1);
        wr(8'h5e, 8'h03);
        wr(8'h5f, 8'h04);
        cyc(3'h7);
        chk();
        chkf(10'h000, 2, 1'b0);
        chkf(10'h220, 4, 1'b0);
        chkf(10'h220, 8, 1'b1);
        chkf(10'h222, 2, 1'b0);
        chkf(10'h01a, 3, 1'b1);
        final_report();
    end
endmodule
